// ---- rtl/clock_select_stab.sv ----
// Purpose: Main clock source select and X1 stabilization status
// Assumes: sys_rst is the OR of all reset sources; inputs are synchronous
// Notes: Reads answer one cycle after rd, from a flop

`timescale 1ns/1ps

module clock_select_stab #(
    // Lowers every threshold by this power of two, for short simulations
    parameter int STAB_SHIFT = 0
) (
    input wire logic clock,
    input wire logic clk_en,
    input wire logic sys_rst,
    input clk_ctl_pkg::bus_req_t bus_req,
    output logic [7:0] rd_data,
    input wire logic stop_enter,
    input wire logic stop_release,
    input wire logic x1_tick,
    input wire logic x1_osc_running,
    output clk_ctl_pkg::clk_sel_t clk_sel,
    output logic x1_osc_enable,
    output logic cpu_hold
);

    // Mode register fields
    logic src_sel_ff, nxt_src_sel;
    logic choice_ff, nxt_choice;
    // Set by first mode write, cleared only by reset
    logic src_lock_ff, nxt_src_lock;
    // Oscillator halt bit
    logic halt_ff, nxt_halt;
    // Wait code as written, and the limit in force for the counter
    logic [2:0] wait_sel_ff, nxt_wait_sel;
    logic [2:0] limit_ff, nxt_limit;
    clk_ctl_pkg::stop_state_t state_ff, nxt_state;
    logic [7:0] rd_data_ff, nxt_rd_data;
    logic [4:0] flags;
    logic stab_done;
    logic stab_clear;
    logic stab_tick;
    logic main_state;
    logic wr_mode, wr_halt, wr_wait;

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (sys_rst);

    // Write decodes
    assign wr_mode = bus_req.wr && (bus_req.addr == clk_ctl_pkg::ADDR_MODE);
    assign wr_halt = bus_req.wr && (bus_req.addr == clk_ctl_pkg::ADDR_HALT_CTL);
    assign wr_wait = bus_req.wr && (bus_req.addr == clk_ctl_pkg::ADDR_WAIT_SEL);

    // Clock source selection; only the main and peripheral clocks are steered
    // other clocks untouched
    assign clk_sel.periph_hs = src_sel_ff;
    assign clk_sel.main_hs = src_sel_ff && choice_ff;
    assign main_state = clk_sel.main_hs;

    // Mode and control registers
    always_comb
    begin
        nxt_src_sel = src_sel_ff;
        nxt_choice = choice_ff;
        nxt_src_lock = src_lock_ff;
        nxt_halt = halt_ff;
        nxt_wait_sel = wait_sel_ff;
        if (wr_mode)
        begin
            nxt_choice = bus_req.wdata[clk_ctl_pkg::CHOICE_BIT];
            if (!src_lock_ff)
            begin
                nxt_src_sel = bus_req.wdata[clk_ctl_pkg::SRC_SEL_BIT];
                nxt_src_lock = 1'b1;
            end
        end
        if (wr_halt)
        begin
            nxt_halt = bus_req.wdata[clk_ctl_pkg::HALT_BIT];
        end
        if (wr_wait)
        begin
            nxt_wait_sel = bus_req.wdata[2:0];
        end
    end

    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            src_sel_ff <= clk_ctl_pkg::MODE_RST[clk_ctl_pkg::SRC_SEL_BIT];
            choice_ff <= clk_ctl_pkg::MODE_RST[clk_ctl_pkg::CHOICE_BIT];
            src_lock_ff <= 1'b0;
            halt_ff <= clk_ctl_pkg::HALT_CTL_RST[clk_ctl_pkg::HALT_BIT];
            wait_sel_ff <= clk_ctl_pkg::WAIT_SEL_RST;
        end
        else if (clk_en)
        begin
            src_sel_ff <= nxt_src_sel;
            choice_ff <= nxt_choice;
            src_lock_ff <= nxt_src_lock;
            halt_ff <= nxt_halt;
            wait_sel_ff <= nxt_wait_sel;
        end
    end

    // STOP sequencing and counter limit
    always_comb
    begin
        nxt_state = state_ff;
        nxt_limit = limit_ff;
        case (state_ff)
            clk_ctl_pkg::ST_RUN:
            begin
                // Latch the wait chosen before STOP
                if (stop_enter)
                begin
                    nxt_state = clk_ctl_pkg::ST_STOP;
                    nxt_limit = wait_sel_ff;
                end
            end
            clk_ctl_pkg::ST_STOP:
            begin
                if (stop_release)
                begin
                    nxt_state = clk_ctl_pkg::ST_WAIT;
                end
            end
            clk_ctl_pkg::ST_WAIT:
            begin
                // A halted oscillator would never finish, so give up the wait
                if (stab_done || halt_ff)
                begin
                    nxt_state = clk_ctl_pkg::ST_RUN;
                end
            end
            default:
            begin
                nxt_state = clk_ctl_pkg::ST_RUN;
            end
        endcase
        // While halted the limit returns to the full span
        if (halt_ff)
        begin
            nxt_limit = clk_ctl_pkg::WAIT_2P16;
        end
    end

    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            state_ff <= clk_ctl_pkg::ST_RUN;
            limit_ff <= clk_ctl_pkg::WAIT_2P16;
        end
        else if (clk_en)
        begin
            state_ff <= nxt_state;
            limit_ff <= nxt_limit;
        end
    end

    // clear on STOP and halt
    // The halt write itself clears, so a read right behind it already sees zero
    assign stab_clear = stop_enter || (state_ff == clk_ctl_pkg::ST_STOP) || halt_ff || nxt_halt;
    assign stab_tick = x1_tick && x1_osc_running;
    // oscillator off while halted or stopped
    assign x1_osc_enable = !halt_ff && (state_ff != clk_ctl_pkg::ST_STOP);
    assign cpu_hold = (state_ff == clk_ctl_pkg::ST_WAIT) && main_state && !stab_done;

    osc_stab_counter #(
        .SHIFT(STAB_SHIFT)
    ) u_stab (
        .clock(clock),
        .clk_en(clk_en),
        .sys_rst(sys_rst),
        .clear(stab_clear),
        .tick(stab_tick),
        .limit_code(limit_ff),
        .flags(flags),
        .done(stab_done)
    );

    // Register reads, unmapped addresses read zero
    always_comb
    begin
        nxt_rd_data = rd_data_ff;
        if (bus_req.rd)
        begin
            case (bus_req.addr)
                clk_ctl_pkg::ADDR_MODE: nxt_rd_data = {5'h00, src_sel_ff, main_state, choice_ff};
                clk_ctl_pkg::ADDR_HALT_CTL: nxt_rd_data = {halt_ff, 7'h00};
                clk_ctl_pkg::ADDR_STATUS: nxt_rd_data = {3'h0, flags};
                clk_ctl_pkg::ADDR_WAIT_SEL: nxt_rd_data = {5'h00, wait_sel_ff};
                default: nxt_rd_data = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            rd_data_ff <= 8'h00;
        end
        else if (clk_en)
        begin
            rd_data_ff <= nxt_rd_data;
        end
    end

    assign rd_data = rd_data_ff;

    internal_default_a: assert property (
        !src_sel_ff |-> (!clk_sel.main_hs && !clk_sel.periph_hs))
        else $error("internal oscillator not selected");
    external_select_a: assert property (
        src_sel_ff |-> (clk_sel.periph_hs && (clk_sel.main_hs == choice_ff)))
        else $error("external source routing wrong");
    status_read_a: assert property (
        (clk_en && bus_req.rd && bus_req.addr == clk_ctl_pkg::ADDR_MODE)
        |=> (rd_data_ff[1] == ($past(src_sel_ff) && $past(choice_ff))))
        else $error("main clock status bit wrong");
    select_once_a: assert property (
        src_lock_ff |=> $stable(src_sel_ff))
        else $error("source select changed after first write");
    status_clear_a: assert property (
        (clk_en && (stop_enter || halt_ff)) |=> (flags == 5'h00))
        else $error("status not cleared");
    stat_read_a: assert property (
        (clk_en && bus_req.rd && bus_req.addr == clk_ctl_pkg::ADDR_STATUS)
        |=> (rd_data_ff == {3'h0, $past(flags)}))
        else $error("status register read wrong");
    cpu_hold_a: assert property (
        (clk_en && state_ff == clk_ctl_pkg::ST_STOP && stop_release && main_state && !halt_ff)
        |=> cpu_hold)
        else $error("CPU not held after STOP release");
    wait_read_a: assert property (
        (clk_en && bus_req.rd && bus_req.addr == clk_ctl_pkg::ADDR_WAIT_SEL)
        |=> (rd_data_ff[7:3] == 5'h00))
        else $error("wait select upper bits not zero");
    osc_gate_a: assert property (
        (clk_en && !x1_osc_running && !stab_clear) |=> $stable(flags))
        else $error("count advanced without oscillation");
    stop_wake_c: cover property (state_ff == clk_ctl_pkg::ST_WAIT && stab_done);
    hold_c: cover property (cpu_hold ##1 !cpu_hold);
    ext_main_c: cover property (src_sel_ff && choice_ff);

endmodule // clock_select_stab

// ---- rtl/clk_ctl_pkg.sv ----
// Purpose: Shared constants and types for the main clock select block
// Assumes: Byte-wide CPU register port, one system clock
// Notes: Stabilization counts are in X1 clock ticks

package clk_ctl_pkg;

    // Register byte addresses
    localparam logic [15:0] ADDR_MODE = 16'hFFA1;
    localparam logic [15:0] ADDR_HALT_CTL = 16'hFFA2;
    localparam logic [15:0] ADDR_STATUS = 16'hFFA3;
    localparam logic [15:0] ADDR_WAIT_SEL = 16'hFFA4;

    // Reset values
    localparam logic [7:0] MODE_RST = 8'h00;
    localparam logic [7:0] HALT_CTL_RST = 8'h80;
    localparam logic [7:0] STATUS_RST = 8'h00;
    localparam logic [2:0] WAIT_SEL_RST = 3'h5;

    // Field positions
    localparam int SRC_SEL_BIT = 2;
    localparam int STATE_BIT = 1;
    localparam int CHOICE_BIT = 0;
    localparam int HALT_BIT = 7;

    // Wait time codes
    localparam logic [2:0] WAIT_2P11 = 3'h1;
    localparam logic [2:0] WAIT_2P13 = 3'h2;
    localparam logic [2:0] WAIT_2P14 = 3'h3;
    localparam logic [2:0] WAIT_2P15 = 3'h4;
    localparam logic [2:0] WAIT_2P16 = 3'h5;

    // Counter width covers the longest wait
    localparam int CNT_W = 17;

    // CPU register access, one byte per access
    typedef struct packed {
        logic [15:0] addr;
        logic wr;
        logic rd;
        logic [7:0] wdata;
    } bus_req_t;

    // Clock source choices, 1 means high-speed system clock
    typedef struct packed {
        logic main_hs;
        logic periph_hs;
    } clk_sel_t;

    // Stop sequencing
    typedef enum logic [1:0] {
        ST_RUN = 2'b00,
        ST_STOP = 2'b01,
        ST_WAIT = 2'b10
    } stop_state_t;

    // X1 ticks for a wait code; prohibited codes take the longest wait
    function automatic logic [CNT_W-1:0] wait_cycles(input logic [2:0] code, input int shift);
        logic [CNT_W-1:0] one;
        one = {{(CNT_W-1){1'b0}}, 1'b1};
        case (code)
            WAIT_2P11: wait_cycles = one << (11 - shift);
            WAIT_2P13: wait_cycles = one << (13 - shift);
            WAIT_2P14: wait_cycles = one << (14 - shift);
            WAIT_2P15: wait_cycles = one << (15 - shift);
            default: wait_cycles = one << (16 - shift);
        endcase
    endfunction

    // Thermometer status, shortest threshold in bit 4
    function automatic logic [4:0] thermo(input logic [CNT_W-1:0] cnt, input int shift);
        thermo = {cnt >= wait_cycles(WAIT_2P11, shift), cnt >= wait_cycles(WAIT_2P13, shift),
                  cnt >= wait_cycles(WAIT_2P14, shift), cnt >= wait_cycles(WAIT_2P15, shift),
                  cnt >= wait_cycles(WAIT_2P16, shift)};
    endfunction

endpackage

// ---- rtl/osc_stab_counter.sv ----
// Purpose: X1 oscillation stabilization counter with status flags
// Assumes: tick is one system cycle per X1 cycle
// Notes: Counting halts at the selected limit

`timescale 1ns/1ps

module osc_stab_counter #(
    parameter int SHIFT = 0
) (
    input wire logic clock,
    input wire logic clk_en,
    input wire logic sys_rst,
    input wire logic clear,
    input wire logic tick,
    input wire logic [2:0] limit_code,
    output logic [4:0] flags,
    output logic done
);

    // Elapsed X1 cycles since last clear
    logic [clk_ctl_pkg::CNT_W-1:0] count_ff;
    logic [clk_ctl_pkg::CNT_W-1:0] nxt_count;
    // Status flags held in flops
    logic [4:0] flags_ff;
    logic [4:0] nxt_flags;
    logic [clk_ctl_pkg::CNT_W-1:0] limit;

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (sys_rst);

    assign limit = clk_ctl_pkg::wait_cycles(limit_code, SHIFT);
    // Handshake level, not stored
    assign done = count_ff >= limit;
    assign flags = flags_ff;

    // Next count and flags
    always_comb
    begin
        nxt_count = count_ff;
        if (clear)
        begin
            nxt_count = '0;
        end
        else if (tick && !done)
        begin
            nxt_count = count_ff + {{(clk_ctl_pkg::CNT_W-1){1'b0}}, 1'b1};
        end
        nxt_flags = clk_ctl_pkg::thermo(nxt_count, SHIFT);
    end

    // Registers, frozen while clk_en is low
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            count_ff <= '0;
            flags_ff <= clk_ctl_pkg::STATUS_RST[4:0];
        end
        else if (clk_en)
        begin
            count_ff <= nxt_count;
            flags_ff <= nxt_flags;
        end
    end

    thermo_shape_a: assert property (
        flags_ff inside {5'h00, 5'h10, 5'h18, 5'h1C, 5'h1E, 5'h1F})
        else $error("status flags not thermometer coded");
    flag_hold_a: assert property (
        (clk_en && !clear) |=> ((flags_ff & $past(flags_ff)) == $past(flags_ff)))
        else $error("status flag dropped without clear");
    count_limit_a: assert property (
        (clk_en && tick && done && !clear) |=> $stable(count_ff))
        else $error("counter ran past selected wait");
    restart_zero_a: assert property (
        (clk_en && clear) |=> (count_ff == '0 && flags_ff == 5'h00))
        else $error("counter not restarted by clear");
    full_flags_c: cover property (flags_ff == 5'h1F);

endmodule // osc_stab_counter

// ---- bench/clock_select_stab_bench.sv ----
// Purpose: Self-checking bench for the main clock select and stabilization block
// Assumes: Inputs change on the falling clock edge, clk_en high but for one freeze test
// Notes: STAB_SHIFT of 8 turns the waits into 8 to 256 ticks

`timescale 1ns/1ps

module clock_select_stab_bench;

    // Shortened thresholds keep the run brief
    localparam int SHIFT = 8;
    localparam logic [15:0] A_MODE = 16'hFFA1;
    localparam logic [15:0] A_HALT = 16'hFFA2;
    localparam logic [15:0] A_STAT = 16'hFFA3;
    localparam logic [15:0] A_WAIT = 16'hFFA4;
    // Cycle ceiling, well above the few thousand cycles the tests need
    localparam int LIMIT = 20000;

    logic clock;
    logic clk_en;
    logic sys_rst;
    clk_ctl_pkg::bus_req_t bus_req;
    logic [7:0] rd_data;
    logic stop_enter;
    logic stop_release;
    logic x1_tick;
    logic x1_osc_running;
    clk_ctl_pkg::clk_sel_t clk_sel;
    logic x1_osc_enable;
    logic cpu_hold;
    int bad_count = 0;
    int checks_done = 0;
    int cycles = 0;
    // Wait codes, their powers of two and the capped status image
    logic [2:0] codes [6] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h0};
    int exps [6] = '{11, 13, 14, 15, 16, 16};
    logic [7:0] stat [6] = '{8'h10, 8'h18, 8'h1C, 8'h1E, 8'h1F, 8'h1F};

    clock_select_stab #(
        .STAB_SHIFT(SHIFT)
    ) i_dut (
        .clock(clock),
        .clk_en(clk_en),
        .sys_rst(sys_rst),
        .bus_req(bus_req),
        .rd_data(rd_data),
        .stop_enter(stop_enter),
        .stop_release(stop_release),
        .x1_tick(x1_tick),
        .x1_osc_running(x1_osc_running),
        .clk_sel(clk_sel),
        .x1_osc_enable(x1_osc_enable),
        .cpu_hold(cpu_hold)
    );

    // Free running 50 MHz clock
    initial
    begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end

    // Verdict and end of run
    task automatic summarize;
        if (bad_count == 0 && checks_done > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // Compare one value and count it
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string msg);
        checks_done++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("Error at %0t ns: %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask

    // Byte write, taken at the next rising edge
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        bus_req.addr = a;
        bus_req.wdata = d;
        bus_req.wr = 1'b1;
        @(negedge clock);
        bus_req.wr = 1'b0;
        // One idle cycle keeps back to back writes apart
        @(negedge clock);
    endtask

    // Byte read; the extra cycle covers the registered answer
    task automatic rc(input logic [15:0] a, input logic [7:0] exp, input string msg);
        bus_req.addr = a;
        bus_req.rd = 1'b1;
        @(negedge clock);
        bus_req.rd = 1'b0;
        @(negedge clock);
        chk(rd_data, exp, msg);
    endtask

    // X1 tick held high for n clock cycles
    task automatic ticks(input int n);
        x1_tick = 1'b1;
        repeat (n) @(negedge clock);
        x1_tick = 1'b0;
    endtask

    // Reset held for four cycles
    task automatic do_reset;
        sys_rst = 1'b1;
        repeat (4) @(negedge clock);
        sys_rst = 1'b0;
    endtask

    task automatic enter_stop;
        stop_enter = 1'b1;
        @(negedge clock);
        stop_enter = 1'b0;
    endtask

    task automatic leave_stop;
        stop_release = 1'b1;
        @(negedge clock);
        stop_release = 1'b0;
    endtask

    // Hang guard: a run past the ceiling fails
    always @(posedge clock)
    begin
        cycles <= cycles + 1;
        if (cycles == LIMIT)
        begin
            bad_count++;
            summarize();
        end
    end

    // Main sequence
    initial
    begin
        int n;
        int prev;
        clk_en = 1'b1;
        bus_req = '0;
        stop_enter = 1'b0;
        stop_release = 1'b0;
        x1_tick = 1'b0;
        x1_osc_running = 1'b0;
        do_reset();
        // Reset image of outputs and registers, plus an unmapped address
        chk({6'h00, clk_sel}, 8'h00, "clock select after reset");
        chk({7'h00, x1_osc_enable}, 8'h00, "oscillator off after reset");
        rc(A_MODE, 8'h00, "mode reset");
        rc(A_HALT, 8'h80, "halt reset");
        rc(A_STAT, 8'h00, "status reset");
        rc(A_WAIT, 8'h05, "wait select reset");
        rc(16'hFFA5, 8'h00, "unmapped read");
        // Upper wait bits stay zero; status ignores writes
        wr(A_WAIT, 8'hFF);
        rc(A_WAIT, 8'h07, "wait select upper bits");
        wr(A_STAT, 8'hFF);
        rc(A_STAT, 8'h00, "status is read only");
        // First write keeps the internal source, so choice alone does nothing
        wr(A_MODE, 8'h01);
        chk({6'h00, clk_sel}, 8'h00, "select zero feeds internal");
        wr(A_MODE, 8'h07);
        chk({6'h00, clk_sel}, 8'h00, "second select write refused");
        rc(A_MODE, 8'h01, "mode after refused select");
        // A new reset reopens the one-shot select
        do_reset();
        rc(A_MODE, 8'h00, "mode after second reset");
        wr(A_MODE, 8'h04);
        chk({6'h00, clk_sel}, 8'h01, "peripheral alone on external");
        rc(A_MODE, 8'h04, "state still internal");
        wr(A_MODE, 8'h01);
        chk({6'h00, clk_sel}, 8'h03, "main follows choice");
        rc(A_MODE, 8'h07, "state external, select kept");
        // Ticks before oscillation really starts do not count
        wr(A_HALT, 8'h00);
        chk({7'h00, x1_osc_enable}, 8'h01, "oscillator enabled");
        ticks(20);
        rc(A_STAT, 8'h00, "no count before start");
        x1_osc_running = 1'b1;
        // Thermometer flags, each checked one tick short and on its threshold
        prev = 0;
        for (int i = 0; i < 5; i++)
        begin
            n = 1 << (exps[i] - SHIFT);
            ticks(n - prev - 1);
            rc(A_STAT, (i == 0) ? 8'h00 : stat[i - 1], "flag one tick early");
            ticks(1);
            rc(A_STAT, stat[i], "flag on threshold");
            prev = n;
        end
        // Halt clears status; the count starts over from zero
        wr(A_HALT, 8'h80);
        chk({7'h00, x1_osc_enable}, 8'h00, "halt stops oscillator");
        rc(A_STAT, 8'h00, "halt clears status");
        wr(A_HALT, 8'h00);
        ticks(7);
        rc(A_STAT, 8'h00, "restart from zero");
        // Clock enable low freezes the count even with ticks arriving
        clk_en = 1'b0;
        ticks(20);
        clk_en = 1'b1;
        rc(A_STAT, 8'h00, "count frozen while disabled");
        // Each wait code through a STOP cycle, CPU on the external clock
        for (int i = 0; i < 6; i++)
        begin
            n = 1 << (exps[i] - SHIFT);
            wr(A_WAIT, {5'h00, codes[i]});
            enter_stop();
            chk({7'h00, x1_osc_enable}, 8'h00, "oscillator off in stop");
            rc(A_STAT, 8'h00, "stop clears status");
            leave_stop();
            chk({7'h00, cpu_hold}, 8'h01, "hold after release");
            // Ticks run on without a gap, so the hold is seen on both sides of the limit
            x1_tick = 1'b1;
            repeat (n - 1) @(negedge clock);
            chk({7'h00, cpu_hold}, 8'h01, "hold one tick early");
            @(negedge clock);
            chk({7'h00, cpu_hold}, 8'h00, "hold ends on wait");
            ticks(300);
            rc(A_STAT, stat[i], "status capped at wait");
        end
        // Reset in mid-run clears status; internal CPU clock is never held
        do_reset();
        rc(A_STAT, 8'h00, "reset clears status");
        rc(A_WAIT, 8'h05, "wait select reset again");
        wr(A_HALT, 8'h00);
        wr(A_WAIT, 8'h02);
        enter_stop();
        leave_stop();
        chk({7'h00, cpu_hold}, 8'h00, "no hold on internal clock");
        // Software polls the status before any switch to the X1 clock
        ticks(40);
        rc(A_STAT, 8'h18, "poll stops at selected wait");
        summarize();
    end

endmodule // clock_select_stab_bench
